// ---- src/phy_mode_map.vh ----
`ifndef PHY_MODE_MAP_VH
`define PHY_MODE_MAP_VH
`define MAC_SGMII     2'h0
`define MAC_QSGMII    2'h1
`define MED_CU        3'h0
`define MED_CONVERT   3'h1
`define MED_1000X     3'h2
`define MED_100FX     3'h3
`define MM_MED_LO     8
`define MM_MED_HI     10
`define MM_XMAC       12
`define CTL_UNIDIR    5
`define CTL_DUPLEX    8
`define CTL_ANEG      12
`define CTL_SPD_MSB   6
`define CTL_SPD_LSB   13
`define MAIN_RST      16'h0000
`define CTL_RST       16'h1140
`define SPD_10        2'h0
`define SPD_100       2'h1
`define SPD_1000      2'h2
`define AW_RST        1'h0
`endif

// ---- src/port_mode_slice.v ----
`default_nettype none
module port_mode_slice (
    input  wire        clk,
    input  wire        reset,
    input  wire        wr_main,
    input  wire        wr_ctl,
    input  wire [15:0] wdata,
    input  wire        mac_xmode,
    input  wire        mac_aneg_en,
    input  wire        sig_detect,
    input  wire        tp_partner_aneg,
    input  wire [1:0]  tp_pd_speed,
    input  wire        media_link_ok,
    output reg  [15:0] main_active,
    output reg  [15:0] ctl_reg,
    output reg  [2:0]  media_mode,
    output reg  [1:0]  speed,
    output reg         duplex,
    output reg         link_up,
    output reg         tx_enable,
    output reg         media_aneg,
    output reg         mac_aneg,
    output reg         unidir_ability,
    output reg         test_feat
);
`include "phy_mode_map.vh"
    reg [15:0] main_pend_reg;
    reg [1:0]  sel_spd;
    reg        sel_dup;
    reg        link_next;
    wire [2:0] med = main_active[`MM_MED_HI:`MM_MED_LO];
    wire       fiber = (med == `MED_1000X) || (med == `MED_100FX);
    // ===========================================
    // pending and active mode
    // ===========================================
    // pending value hidden; reads show active mode only
    always @(posedge clk) begin
        if (reset) begin
            main_pend_reg <= `MAIN_RST;
            main_active   <= `MAIN_RST;
            ctl_reg       <= `CTL_RST;
        end else begin
            if (wr_main)
                main_pend_reg <= wdata;
            if (wr_ctl && wdata[15]) begin
                main_active <= wr_main ? wdata : main_pend_reg;
                ctl_reg     <= {1'b0, wdata[14:0]};
            end else if (wr_ctl) begin
                ctl_reg <= wdata;
            end
        end
    end
    // ===========================================
    // speed and duplex selection
    // ===========================================
    always @* begin
        sel_spd = `SPD_1000;
        sel_dup = 1'b1;
        link_next = media_link_ok;
        if (mac_xmode) begin
            sel_spd = `SPD_1000;
        end else if (med == `MED_1000X) begin
            sel_spd = `SPD_1000;
        end else if (med == `MED_100FX) begin
            sel_spd = `SPD_100;
            sel_dup = ctl_reg[`CTL_DUPLEX];
        end else if (med == `MED_CONVERT) begin
            link_next = media_link_ok && sig_detect;
        end else if (!ctl_reg[`CTL_ANEG]) begin
            sel_spd = {ctl_reg[`CTL_SPD_MSB], ctl_reg[`CTL_SPD_LSB]};
            sel_dup = ctl_reg[`CTL_DUPLEX];
            // 1000 forced cannot link without negotiation
            if (sel_spd == `SPD_1000)
                link_next = 1'b0;
        end else if (!tp_partner_aneg) begin
            sel_spd = tp_pd_speed;
            sel_dup = 1'b0;
        end
    end
    always @(posedge clk) begin
        if (reset) begin
            media_mode     <= `MED_CU;
            speed          <= `SPD_1000;
            duplex         <= 1'b1;
            link_up        <= 1'b0;
            tx_enable      <= 1'b0;
            media_aneg     <= 1'b0;
            mac_aneg       <= 1'b0;
            unidir_ability <= 1'b0;
            test_feat      <= 1'b0;
        end else begin
            media_mode <= med;
            speed      <= sel_spd;
            duplex     <= sel_dup;
            link_up    <= link_next;
            tx_enable  <= link_next ||
                          (fiber && ctl_reg[`CTL_UNIDIR]);
            media_aneg <= ctl_reg[`CTL_ANEG] &&
                          (med != `MED_100FX);
            mac_aneg   <= mac_aneg_en;
            unidir_ability <= fiber;
            test_feat  <= fiber;
        end
    end
endmodule
`default_nettype wire

// ---- src/phy_interface_mode_config.v ----
// Summary of operation
// - one global mac mode for all ports
// - broadcast bit writes all ports together
// - xmac mode bit gives 1000 only
// - mac autoneg only with enable bit
// - mode 00, xmac clear: sgmii all rates
// - mode 01: qsgmii four ports
// - decode 00 sgmii, 01 qsgmii, others reserved
// - media 010 selects 1000base-x per port
// - 1000base-x autoneg from control bit 12; none on 100base-fx
// - copper sfp at 1000 only there
// - media 011 selects 100base-fx
// - conversion links only with signal detect while xmac clear
// - conversion hides the duplex led (LED_FULL_SET)
// - media mode change needs soft reset
// - unidirectional bit forces fiber transmit
// - address is strap shl one plus port, or plus three minus port when reversed
// - autoneg off: forced speed and duplex
// - parallel detect for non-negotiating partner
// - 1000base-t needs autonegotiation while xmac clear
// - mode write pends; read shows active
`default_nettype none
module phy_interface_mode_config (
    input  wire        SYS_CLK,
    input  wire        RESET,
    input  wire        GMODE_WR,
    input  wire [1:0]  GMODE_DATA,
    input  wire        BCAST_WR_EN,
    input  wire [1:0]  WR_PORT,
    input  wire        MAIN_WR,
    input  wire        CTL_WR,
    input  wire [15:0] WR_DATA,
    input  wire [3:0]  MAC_ANEG_EN,
    input  wire        ADDR_REVERSE,
    input  wire [3:0]  ADDRESS_STRAP_PINS,
    input  wire [3:0]  SIG_DETECT,
    input  wire [3:0]  TP_PARTNER_ANEG,
    input  wire [7:0]  TP_PD_SPEED,
    input  wire [3:0]  MEDIA_LINK_OK,
    output reg  [1:0]  MAC_MODE,
    output reg         MAC_MODE_RSVD,
    output reg         QSGMII_ON,
    output reg  [19:0] PORT_ADDR,
    output reg  [63:0] MAIN_READ,
    output reg  [63:0] CTL_READ,
    output reg  [11:0] MEDIA_MODE,
    output reg  [7:0]  SPEED,
    output reg  [3:0]  DUPLEX,
    output reg  [3:0]  LINK_UP,
    output reg  [3:0]  TX_ENABLE,
    output reg  [3:0]  MEDIA_ANEG,
    output reg  [3:0]  MAC_ANEG,
    output reg  [3:0]  UNIDIR_ABILITY,
    output reg  [3:0]  TEST_FEAT,
    output reg  [3:0]  LED_FULL_SET
);
`include "phy_mode_map.vh"
    reg [1:0]   mac_mode_reg;
    reg [3:0]   strap_s1;
    reg [3:0]   strap_s2;
    reg [3:0]   strap_s3;
    reg [3:0]   strap_clean;
    reg [3:0]   sd_s1;
    reg [3:0]   sd_s2;
    reg [3:0]   sd_s3;
    reg [3:0]   sd_clean;
    wire [63:0] m_act;
    wire [63:0] c_reg;
    wire [11:0] med_w;
    wire [7:0]  spd_w;
    wire [3:0]  dup_w;
    wire [3:0]  lnk_w;
    wire [3:0]  txe_w;
    wire [3:0]  man_w;
    wire [3:0]  mac_w;
    wire [3:0]  uni_w;
    wire [3:0]  tst_w;
    wire        xmode = m_act[`MM_XMAC];
    // ===========================================
    // address arithmetic
    // ===========================================
    function [4:0] port_address;
        input [3:0] strap;
        input [1:0] idx;
        input       rev;
        begin
            port_address = {strap, 1'b0} +
                           {3'h0, rev ? (2'h3 - idx) : idx};
        end
    endfunction
    // ===========================================
    // global mode and pin synchronisers
    // ===========================================
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            mac_mode_reg <= `MAC_SGMII;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            strap_s3 <= 4'h0;
            strap_clean <= 4'h0;
            sd_s1    <= 4'h0;
            sd_s2    <= 4'h0;
            sd_s3    <= 4'h0;
            sd_clean <= 4'h0;
        end else begin
            if (GMODE_WR)
                mac_mode_reg <= GMODE_DATA;
            strap_s1 <= ADDRESS_STRAP_PINS;
            strap_s2 <= strap_s1;
            strap_s3 <= strap_s2;
            // strap counts once second and third stage agree
            strap_clean <= (strap_s2 & strap_s3) |
                           (strap_clean & (strap_s2 | strap_s3));
            sd_s1    <= SIG_DETECT;
            sd_s2    <= sd_s1;
            sd_s3    <= sd_s2;
            // only a settled level counts
            sd_clean <= (sd_s2 & sd_s3) | (sd_clean & (sd_s2 | sd_s3));
        end
    end
    // ===========================================
    // per-port slices
    // ===========================================
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gp
            wire hit = BCAST_WR_EN || (WR_PORT == g);
            port_mode_slice u_slice (
                .clk             (SYS_CLK),
                .reset           (RESET),
                .wr_main         (MAIN_WR && hit),
                .wr_ctl          (CTL_WR && hit),
                .wdata           (WR_DATA),
                .mac_xmode       (xmode),
                .mac_aneg_en     (MAC_ANEG_EN[g]),
                .sig_detect      (sd_clean[g]),
                .tp_partner_aneg (TP_PARTNER_ANEG[g]),
                .tp_pd_speed     (TP_PD_SPEED[2*g+1:2*g]),
                .media_link_ok   (MEDIA_LINK_OK[g]),
                .main_active     (m_act[16*g+15:16*g]),
                .ctl_reg         (c_reg[16*g+15:16*g]),
                .media_mode      (med_w[3*g+2:3*g]),
                .speed           (spd_w[2*g+1:2*g]),
                .duplex          (dup_w[g]),
                .link_up         (lnk_w[g]),
                .tx_enable       (txe_w[g]),
                .media_aneg      (man_w[g]),
                .mac_aneg        (mac_w[g]),
                .unidir_ability  (uni_w[g]),
                .test_feat       (tst_w[g])
            );
        end
    endgenerate
    // ===========================================
    // registered outputs
    // ===========================================
    // one cycle behind slice outputs; keeps top outputs on flops
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            MAC_MODE       <= `MAC_SGMII;
            MAC_MODE_RSVD  <= 1'b0;
            QSGMII_ON      <= 1'b0;
            PORT_ADDR      <= 20'h00000;
            MAIN_READ      <= 64'h0;
            CTL_READ       <= 64'h0;
            MEDIA_MODE     <= 12'h000;
            SPEED          <= 8'h00;
            DUPLEX         <= 4'h0;
            LINK_UP        <= 4'h0;
            TX_ENABLE      <= 4'h0;
            MEDIA_ANEG     <= 4'h0;
            MAC_ANEG       <= 4'h0;
            UNIDIR_ABILITY <= 4'h0;
            TEST_FEAT      <= 4'h0;
            LED_FULL_SET   <= 4'h0;
        end else begin
            MAC_MODE      <= mac_mode_reg;
            MAC_MODE_RSVD <= mac_mode_reg[1];
            QSGMII_ON     <= (mac_mode_reg == `MAC_QSGMII);
            PORT_ADDR <= {port_address(strap_clean, 2'h3, ADDR_REVERSE),
                          port_address(strap_clean, 2'h2, ADDR_REVERSE),
                          port_address(strap_clean, 2'h1, ADDR_REVERSE),
                          port_address(strap_clean, 2'h0, ADDR_REVERSE)};
            MAIN_READ      <= m_act;
            CTL_READ       <= c_reg;
            MEDIA_MODE     <= med_w;
            SPEED          <= spd_w;
            DUPLEX         <= dup_w;
            LINK_UP        <= lnk_w;
            TX_ENABLE      <= txe_w;
            MEDIA_ANEG     <= man_w;
            MAC_ANEG       <= mac_w;
            UNIDIR_ABILITY <= uni_w;
            TEST_FEAT      <= tst_w;
            LED_FULL_SET   <= {med_w[11:9] != `MED_CONVERT,
                               med_w[8:6] != `MED_CONVERT,
                               med_w[5:3] != `MED_CONVERT,
                               med_w[2:0] != `MED_CONVERT};
        end
    end
endmodule
`default_nettype wire

// ---- verification/phy_mode_props.sv ----
`default_nettype none
module phy_mode_props (
    input wire logic        SYS_CLK,
    input wire logic        RESET,
    input wire logic        GMODE_WR,
    input wire logic [1:0]  GMODE_DATA,
    input wire logic        BCAST_WR_EN,
    input wire logic        MAIN_WR,
    input wire logic        CTL_WR,
    input wire logic [15:0] WR_DATA,
    input wire logic [1:0]  MAC_MODE,
    input wire logic        MAC_MODE_RSVD,
    input wire logic        QSGMII_ON,
    input wire logic [63:0] MAIN_READ,
    input wire logic [63:0] CTL_READ,
    input wire logic [11:0] MEDIA_MODE,
    input wire logic [3:0]  TX_ENABLE,
    input wire logic [3:0]  UNIDIR_ABILITY,
    input wire logic [3:0]  TEST_FEAT,
    input wire logic [3:0]  LED_FULL_SET
);
timeunit 1ns;
timeprecision 1ps;
// ============================================================
// mode checks; port 0 watched, the bench spreads traffic
default clocking @(posedge SYS_CLK); endclocking
default disable iff (RESET);
sequence s_bmain; MAIN_WR && BCAST_WR_EN && !CTL_WR; endsequence
sequence s_bsoft;
    CTL_WR && BCAST_WR_EN && WR_DATA[15] && !MAIN_WR;
endsequence
property p_gmode; GMODE_WR |-> ##2 MAC_MODE == $past(GMODE_DATA, 2); endproperty
a_gmode: assert property (p_gmode)
    else $error("mac mode not loaded");
property p_rsvd; GMODE_WR |-> ##2 MAC_MODE_RSVD == $past(GMODE_DATA[1], 2)
    && QSGMII_ON == ($past(GMODE_DATA, 2) == 2'h1); endproperty
a_rsvd: assert property (p_rsvd)
    else $error("mac mode decode wrong");
property p_pend; !$past(CTL_WR && WR_DATA[15], 2) |-> $stable(MAIN_READ);
endproperty
a_pend: assert property (p_pend)
    else $error("active mode moved without soft reset");
property p_bcast;
    s_bmain ##1 s_bsoft |-> ##2 MAIN_READ == {4{$past(WR_DATA, 3)}};
endproperty
a_bcast: assert property (p_bcast)
    else $error("broadcast write missed a port");
property p_media;
    MEDIA_MODE == {$past(MAIN_READ[58:56]), $past(MAIN_READ[42:40]),
    $past(MAIN_READ[26:24]), $past(MAIN_READ[10:8])};
endproperty
a_media: assert property (p_media)
    else $error("media mode not from active mode");
property p_unidir;
    (MEDIA_MODE[2:1] == 2'h1 && CTL_READ[5]) [*2] |-> TX_ENABLE[0];
endproperty
a_unidir: assert property (p_unidir)
    else $error("fiber transmit not forced");
property p_ability; UNIDIR_ABILITY[0] == (MEDIA_MODE[2:1] == 2'h1)
    && TEST_FEAT[0] == (MEDIA_MODE[2:1] == 2'h1); endproperty
a_ability: assert property (p_ability)
    else $error("fiber abilities wrong");
property p_led; MEDIA_MODE[2:0] == 3'h1 |-> !LED_FULL_SET[0]; endproperty
a_led: assert property (p_led)
    else $error("duplex led shown in conversion");
endmodule
bind phy_interface_mode_config phy_mode_props chk (.*);
`default_nettype wire

// ---- verification/link_partner_model.sv ----
`default_nettype none
module link_partner_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [3:0] link_req,
    input  wire logic [3:0] sd_req,
    input  wire logic [3:0] aneg_req,
    input  wire logic [7:0] speed_req,
    output logic      [3:0] link_ok,
    output logic      [3:0] sig_detect,
    output logic      [3:0] tp_aneg,
    output logic      [7:0] pd_speed
);
timeunit 1ns;
timeprecision 1ps;
// ============================================================
// slow partner lags three cycles, like a module still training
logic [11:0] d1, d2, d3;
always @(posedge clk) begin
    d1 <= {link_req, sd_req, aneg_req};
    d2 <= d1;
    d3 <= d2;
end
assign {link_ok, sig_detect, tp_aneg} = slow ? d3 : d1;
assign pd_speed = speed_req;
endmodule
`default_nettype wire

// ---- verification/phy_interface_mode_config_bench.sv ----
`default_nettype none
module phy_interface_mode_config_bench;
timeunit 1ns;
timeprecision 1ps;
logic SYS_CLK, RESET, GMODE_WR, BCAST_WR_EN, MAIN_WR, CTL_WR, ADDR_REVERSE;
logic MAC_MODE_RSVD, QSGMII_ON, slow;
logic [1:0] GMODE_DATA, WR_PORT, MAC_MODE;
logic [3:0] MAC_ANEG_EN, ADDRESS_STRAP_PINS, SIG_DETECT, TP_PARTNER_ANEG;
logic [3:0] MEDIA_LINK_OK, DUPLEX, LINK_UP, TX_ENABLE, MEDIA_ANEG, MAC_ANEG;
logic [3:0] UNIDIR_ABILITY, TEST_FEAT, LED_FULL_SET, link_req, sd_req, aneg_req;
logic [7:0] TP_PD_SPEED, SPEED, speed_req;
logic [11:0] MEDIA_MODE;
logic [15:0] WR_DATA, d;
logic [15:0] act [4];
logic [19:0] PORT_ADDR;
logic [63:0] MAIN_READ, CTL_READ;
int errors = 0, n_checks = 0, cyc = 0, p, i;
phy_interface_mode_config dut (.*);
link_partner_model lp (.clk(SYS_CLK), .slow(slow), .link_req(link_req),
    .sd_req(sd_req), .aneg_req(aneg_req), .speed_req(speed_req),
    .link_ok(MEDIA_LINK_OK), .sig_detect(SIG_DETECT),
    .tp_aneg(TP_PARTNER_ANEG), .pd_speed(TP_PD_SPEED));
// ============================================================
// helpers
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
        errors++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic wr(input logic m, c, b, input logic [1:0] pt, input logic [15:0] v);
    @(negedge SYS_CLK);
    {MAIN_WR, CTL_WR, BCAST_WR_EN, WR_PORT, WR_DATA} = {m, c, b, pt, v};
endtask
task automatic idle(input int n);
    @(negedge SYS_CLK);
    {MAIN_WR, CTL_WR, GMODE_WR} = 3'h0;
    repeat (n) @(negedge SYS_CLK);
endtask
function automatic logic [19:0] addr_exp(input logic [3:0] s, input logic r);
    for (int k = 0; k < 4; k++) addr_exp[5*k +: 5] = {s, 1'b0} + 5'(r ? 3 - k : k);
endfunction
task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
initial begin
    SYS_CLK = 0;
    forever #5 SYS_CLK = ~SYS_CLK;
end
// a full run needs under a thousand cycles
always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
        errors++;
        end_of_test;
    end
end
// ============================================================
// tests
initial begin
    {GMODE_WR, MAIN_WR, CTL_WR, BCAST_WR_EN, ADDR_REVERSE, slow} = 6'h0;
    {GMODE_DATA, WR_PORT, WR_DATA, MAC_ANEG_EN, ADDRESS_STRAP_PINS} = 28'h0;
    {link_req, sd_req, aneg_req, speed_req} = 20'h0;
    act = '{default: 16'h0};
    d = 16'($urandom(45));
    RESET = 1;
    repeat (2) @(negedge SYS_CLK);
    RESET = 0;
    idle(3);
    chk(CTL_READ, {4{16'h1140}});
    chk(MAIN_READ, 64'h0);
    for (i = 0; i < 4; i++) begin
        GMODE_WR = 1;
        GMODE_DATA = i[1:0];
        idle(2);
        chk({MAC_MODE, MAC_MODE_RSVD, QSGMII_ON}, {i[1:0], i[1], i == 1});
    end
    $display("test mac mode done");
    for (i = 0; i < 4; i++) begin
        p = $urandom_range(3);
        MAC_ANEG_EN = 4'($urandom);
        d = {5'h0, i[2:0], 8'($urandom)};
        wr(1, 0, 0, p[1:0], d);
        idle(3);
        chk(MAIN_READ[16*p +: 16], act[p]);
        wr(0, 1, 0, p[1:0], 16'h9140);
        idle(3);
        act[p] = d;
        chk(MAIN_READ[16*p +: 16], d);
        chk(MEDIA_MODE[3*p +: 3], i[2:0]);
        chk({UNIDIR_ABILITY[p], TEST_FEAT[p]}, {2{i[1]}});
        chk(MAC_ANEG[p], MAC_ANEG_EN[p]);
        chk(MEDIA_ANEG[p], i != 3);
    end
    $display("test media mode done");
    d = {5'h0, 3'h2, 8'($urandom)};
    MAC_ANEG_EN = 4'h0;
    wr(1, 0, 1, 2'h0, d);
    wr(0, 1, 1, 2'h0, 16'h8160);
    idle(3);
    chk(MAIN_READ, {4{d}});
    chk(TX_ENABLE, 4'hf);
    $display("test broadcast done");
    for (i = 0; i < 6; i++) begin
        ADDRESS_STRAP_PINS = i ? 4'($urandom) : 4'hf;
        ADDR_REVERSE = i[0];
        idle(6);
        chk(PORT_ADDR, addr_exp(ADDRESS_STRAP_PINS, ADDR_REVERSE));
    end
    $display("test address done");
    link_req = 4'hf;
    slow = 1;
    for (i = 0; i < 3; i++) begin
        d = {2'b10, i[0], 4'h0, d[0], 1'b0, i[1], 6'h0};
        wr(1, 0, 1, 2'h0, 16'h0);
        wr(0, 1, 1, 2'h0, d);
        idle(6);
        chk(SPEED, {4{i[1:0]}});
        chk(DUPLEX, {4{d[8]}});
        chk(LINK_UP, i == 2 ? 4'h0 : 4'hf);
    end
    speed_req = 8'($urandom) & 8'h55;
    wr(0, 1, 1, 2'h0, 16'h9000);
    idle(6);
    chk(SPEED, speed_req);
    chk(DUPLEX, 4'h0);
    // 10/100 adverts assumed cleared by software in this mode
    wr(1, 0, 1, 2'h0, 16'h1000);
    wr(0, 1, 1, 2'h0, 16'ha000);
    idle(6);
    chk(SPEED, 8'haa);
    $display("test twisted pair done");
    slow = 0;
    wr(1, 0, 1, 2'h0, 16'h0100);
    wr(0, 1, 1, 2'h0, 16'h9140);
    idle(10);
    chk({LINK_UP, LED_FULL_SET}, 8'h0);
    sd_req = 4'hf;
    idle(10);
    chk(LINK_UP, 4'hf);
    $display("test conversion done");
    end_of_test;
end
endmodule
`default_nettype wire
